// *** logic/emac_pkg.sv ***
// package: register map, field layout and constants for the monitor/align control bank
package emac_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned PTR_W = 9;
  localparam logic [7:0] OFS_LB_TXMON = 8'ha8;
  localparam logic [7:0] OFS_RXMON_ALIGN = 8'haa;
  localparam logic [7:0] RST_LB_TXMON = 8'h00;
  localparam logic [7:0] RST_RXMON_ALIGN = 8'h00;
  localparam int unsigned POS_LOOPBACK = 7;
  localparam int unsigned POS_RX_ALIGN = 6;
  localparam int unsigned POS_TX_ALIGN = 5;
  localparam int unsigned POS_SEL_MSB = 4;
  localparam int unsigned POS_SEL_LSB = 0;
  localparam logic [7:0] MASK_LB_TXMON = 8'h9f;
  localparam logic [7:0] MASK_RXMON_ALIGN = 8'h7f;
  localparam int unsigned FRAME_BYTES = 32;
  localparam int unsigned STORE_BYTES = 64;
  localparam logic [PTR_W-1:0] HALF_FRAME = 9'h010;
endpackage

// *** logic/emac_align_if.sv ***
// interface: align request and pointer status between register bank and aligner
`timescale 1ns/10ps
interface emac_align_if;
  import emac_pkg::*;
  logic req;
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic force_pulse;
  logic [PTR_W-1:0] force_rd_ptr;
  modport bank (output req, wr_ptr, rd_ptr, input force_pulse, force_rd_ptr);
  modport aligner (input req, wr_ptr, rd_ptr, output force_pulse, force_rd_ptr);
endinterface

// *** logic/emac_aligner.sv ***
// edge-triggered elastic store aligner: one per store direction
`timescale 1ns/10ps
module emac_aligner
  import emac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  emac_align_if.aligner al
);
  logic req_d_r;
  logic force_r;
  logic [PTR_W-1:0] target_r;
  wire rise = al.req & ~req_d_r;
  wire [PTR_W-1:0] sep = al.wr_ptr - al.rd_ptr;
  wire too_close = sep < HALF_FRAME;
  // read pointer placed half a store behind the writer
  wire [PTR_W-1:0] target = al.wr_ptr - PTR_W'(STORE_BYTES / 2);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      req_d_r <= 1'b0;
      force_r <= 1'b0;
      target_r <= '0;
    end
    else
    begin
      req_d_r <= al.req;
      force_r <= rise & too_close;
      target_r <= target;
    end
  end

  // a level held high gives only one edge, so no repeated realign
  assign al.force_pulse = force_r;
  assign al.force_rd_ptr = target_r;
endmodule

// *** logic/emac_ctrl.sv ***
// top: loopback/monitor select and elastic store align control registers
`timescale 1ns/10ps
module emac_ctrl
  import emac_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  input wire logic [PTR_W-1:0] tx_wr_ptr,
  input wire logic [PTR_W-1:0] tx_rd_ptr,
  input wire logic [PTR_W-1:0] rx_wr_ptr,
  input wire logic [PTR_W-1:0] rx_rd_ptr,
  output logic tx_force_pulse,
  output logic [PTR_W-1:0] tx_force_rd_ptr,
  output logic rx_force_pulse,
  output logic [PTR_W-1:0] rx_force_rd_ptr,
  output logic far_end_loopback_enable,
  output logic [SEL_W-1:0] tx_monitor_select,
  output logic [SEL_W-1:0] rx_monitor_select
);
  logic loopback_r;
  logic [SEL_W-1:0] tx_sel_r;
  logic [SEL_W-1:0] rx_sel_r;
  logic tx_align_r;
  logic rx_align_r;
  logic [DATA_W-1:0] rdata_r;
  logic tx_fp_r;
  logic rx_fp_r;
  logic [PTR_W-1:0] tx_fr_r;
  logic [PTR_W-1:0] rx_fr_r;
  emac_align_if tx_if();
  emac_align_if rx_if();

  // one offset compare shared by the write and the read decode
  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] a,
    input logic [ADDR_W-1:0] ofs
  );
    return a == ofs;
  endfunction

  // both registers keep their channel select in the same low bits
  function automatic logic [SEL_W-1:0] sel_field(
    input logic [DATA_W-1:0] d
  );
    return d[POS_SEL_MSB:POS_SEL_LSB];
  endfunction

  // unassigned bits are not stored, so they read back zero whatever was written
  function automatic logic [DATA_W-1:0] pack_lb(
    input logic lb,
    input logic [SEL_W-1:0] sel
  );
    logic [DATA_W-1:0] v;
    v = '0;
    v[POS_LOOPBACK] = lb;
    v[POS_SEL_MSB:POS_SEL_LSB] = sel;
    return v;
  endfunction

  function automatic logic [DATA_W-1:0] pack_rx(
    input logic rx_al,
    input logic tx_al,
    input logic [SEL_W-1:0] sel
  );
    logic [DATA_W-1:0] v;
    v = '0;
    v[POS_RX_ALIGN] = rx_al;
    v[POS_TX_ALIGN] = tx_al;
    v[POS_SEL_MSB:POS_SEL_LSB] = sel;
    return v;
  endfunction

  wire hit_lb = reg_hit(addr, OFS_LB_TXMON);
  wire hit_rx = reg_hit(addr, OFS_RXMON_ALIGN);
  wire wr_lb = wr_en & hit_lb;
  wire wr_rx = wr_en & hit_rx;
  wire loopback_nxt = wr_lb ? wdata[POS_LOOPBACK] : loopback_r;
  wire [SEL_W-1:0] tx_sel_nxt = wr_lb ? sel_field(wdata) : tx_sel_r;
  wire [SEL_W-1:0] rx_sel_nxt = wr_rx ? sel_field(wdata) : rx_sel_r;
  // align bits are plain levels here; the aligners look for the rising edge
  wire tx_align_nxt = wr_rx ? wdata[POS_TX_ALIGN] : tx_align_r;
  wire rx_align_nxt = wr_rx ? wdata[POS_RX_ALIGN] : rx_align_r;
  wire [DATA_W-1:0] lb_view = pack_lb(loopback_r, tx_sel_r);
  wire [DATA_W-1:0] rx_view = pack_rx(rx_align_r, tx_align_r, rx_sel_r);
  wire [DATA_W-1:0] rd_mux = hit_lb ? lb_view : (hit_rx ? rx_view : 8'h00);
  wire [DATA_W-1:0] rdata_nxt = rd_en ? rd_mux : rdata_r;

  // software must only toggle align once the backplane clocks are stable
  assign tx_if.req = tx_align_r;
  assign rx_if.req = rx_align_r;
  assign tx_if.wr_ptr = tx_wr_ptr;
  assign tx_if.rd_ptr = tx_rd_ptr;
  assign rx_if.wr_ptr = rx_wr_ptr;
  assign rx_if.rd_ptr = rx_rd_ptr;

  emac_aligner u_tx_align (
    .clk_sys(clk_sys),
    .reset(reset),
    .al(tx_if.aligner)
  );
  emac_aligner u_rx_align (
    .clk_sys(clk_sys),
    .reset(reset),
    .al(rx_if.aligner)
  );

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      loopback_r <= RST_LB_TXMON[POS_LOOPBACK];
    end
    else
    begin
      loopback_r <= loopback_nxt;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_sel_r <= sel_field(RST_LB_TXMON);
    end
    else
    begin
      tx_sel_r <= tx_sel_nxt;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rx_sel_r <= sel_field(RST_RXMON_ALIGN);
    end
    else
    begin
      rx_sel_r <= rx_sel_nxt;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_align_r <= RST_RXMON_ALIGN[POS_TX_ALIGN];
    end
    else
    begin
      tx_align_r <= tx_align_nxt;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rx_align_r <= RST_RXMON_ALIGN[POS_RX_ALIGN];
    end
    else
    begin
      rx_align_r <= rx_align_nxt;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // extra flop so every output leaves from a register; costs one cycle of latency
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_fp_r <= 1'b0;
    end
    else
    begin
      tx_fp_r <= tx_if.force_pulse;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rx_fp_r <= 1'b0;
    end
    else
    begin
      rx_fp_r <= rx_if.force_pulse;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_fr_r <= '0;
    end
    else
    begin
      tx_fr_r <= tx_if.force_rd_ptr;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rx_fr_r <= '0;
    end
    else
    begin
      rx_fr_r <= rx_if.force_rd_ptr;
    end
  end

  assign rdata = rdata_r;
  assign tx_force_pulse = tx_fp_r;
  assign rx_force_pulse = rx_fp_r;
  assign tx_force_rd_ptr = tx_fr_r;
  assign rx_force_rd_ptr = rx_fr_r;
  assign far_end_loopback_enable = loopback_r;
  assign tx_monitor_select = tx_sel_r;
  assign rx_monitor_select = rx_sel_r;
endmodule

// *** sim/emac_ctrl_props.sv ***
// checker: monitor select and align pulse timing
`timescale 1ns/10ps
module emac_ctrl_props import emac_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic tx_force_pulse,
  input wire logic rx_force_pulse,
  input wire logic [SEL_W-1:0] rx_monitor_select
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (reset);
  wire wb = wr_en && addr == OFS_RXMON_ALIGN;
  wire tp = tx_force_pulse;
  wire rp = rx_force_pulse;
  // a clearing write can never be followed by a pulse three cycles on
  sequence tclr; wb && !wdata[5]; endsequence
  sequence rclr; wb && !wdata[6]; endsequence
  chk_rx_sel: assert property (wb |=> rx_monitor_select == $past(wdata[4:0]))
    else $error("rx select");
  chk_rx_hold: assert property (!wb |=> $stable(rx_monitor_select)) else $error("rx hold");
  chk_tx_once: assert property (tp |=> !tp) else $error("tx long");
  chk_rx_once: assert property (rp |=> !rp) else $error("rx long");
  chk_tx_cause: assert property (tp |-> $past(wb, 3) && $past(wdata[5], 3))
    else $error("tx cause");
  chk_rx_cause: assert property (rp |-> $past(wb, 3) && $past(wdata[6], 3))
    else $error("rx cause");
  chk_tx_clear: assert property (tclr |-> ##3 !tp) else $error("tx clr");
  chk_rx_clear: assert property (rclr |-> ##3 !rp) else $error("rx clr");
endmodule
bind emac_ctrl emac_ctrl_props u_emac_ctrl_props (.*);

// *** sim/emac_ctrl_bench.sv ***
// bench: register bank and align pulses against a model
`timescale 1ns/10ps
module emac_ctrl_bench import emac_pkg::*;;
  logic clk_sys = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0, far_end_loopback_enable;
  logic tx_force_pulse, rx_force_pulse;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, r;
  logic [8:0] tx_wr_ptr = 9'h105, rx_wr_ptr = 9'h105, tx_rd_ptr = 9'h100, rx_rd_ptr = 9'h100;
  logic [8:0] tx_force_rd_ptr, rx_force_rd_ptr;
  logic [4:0] tx_monitor_select, rx_monitor_select;
  logic [79:0] dl = 80'h00404000600020200000;
  int n_fail = 0, samples_checked = 0, n;
  always #10 clk_sys = ~clk_sys;
  emac_ctrl u_emac_ctrl (.*);
  task automatic chk(logic [8:0] g, logic [8:0] e);
    samples_checked++;
    n_fail += int'(g !== e);
    if (g !== e) $display("[ERR] %0t got %h exp %h", $time, g, e);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic re);
    @(posedge clk_sys);
    {addr, wdata, wr_en, rd_en} <= {a, d, !re, re};
    @(posedge clk_sys);
    {wr_en, rd_en} <= 2'b00;
    #1;
  endtask
  task automatic wrap_up;
    if (n_fail == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(53388));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    wr(8'h00, 8'h00, 1'b1);
    chk(rdata, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      r = 8'($urandom);
      wr(OFS_LB_TXMON, r & MASK_LB_TXMON, 1'b0);
      wr(OFS_RXMON_ALIGN, r & 8'h1f, 1'b0);
      chk({far_end_loopback_enable, tx_monitor_select}, {r[7], r[4:0]});
      chk(rx_monitor_select, r[4:0]);
      wr(OFS_LB_TXMON, 8'h00, 1'b1);
      chk(rdata, r & MASK_LB_TXMON);
      wr(OFS_RXMON_ALIGN, 8'h00, 1'b1);
      chk(rdata, r & 8'h1f);
    end
    // align steps: set, hold high, set at 16 apart, set at 15 apart
    // the clock runs from time zero, so every align toggle meets a stable clock
    for (int i = 0; i < 9; i++)
    begin
      r = dl[8*i+8 +: 8];
      @(posedge clk_sys);
      {tx_rd_ptr, rx_rd_ptr} <= {2{i < 3 ? 9'h100 : i < 5 ? 9'h0f5 : 9'h0f6}};
      wr(OFS_RXMON_ALIGN, r, 1'b0);
      n = 0;
      repeat (6)
      begin
        @(posedge clk_sys) #1 n += tx_force_pulse + 2 * rx_force_pulse;
        if (tx_force_pulse) chk(tx_force_rd_ptr, 9'h0e5);
        if (rx_force_pulse) chk(rx_force_rd_ptr, 9'h0e5);
      end
      chk(n, ((r & ~dl[8*i +: 8]) >> 5) & {2{i < 3 || i > 4}});
    end
    // mid-run reset must clear the loopback and tx select fields
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    #1;
    chk({far_end_loopback_enable, tx_monitor_select}, 9'h000);
    wrap_up();
  end
endmodule
